// ### hw/cgc_pkg.sv
// constants, mode codes and register map of the clock generator control block
// assumes an apb master with 32-bit data and one 25 MHz clock
package cgc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    // control one field positions
    localparam int C1_HGO = 7;
    localparam int C1_RANGE = 6;
    localparam int C1_EXT_REFERENCE_SELECT = 5;
    localparam int C1_MODE_HI = 4;
    localparam int C1_MODE_LO = 3;
    localparam int C1_STEN = 2;
    localparam int C1_LOSS_DETECT_DISABLE = 1;
    // control two field positions
    localparam int C2_LOCK_LOSS_RESET_ENABLE = 7;
    localparam int C2_MFD_HI = 6;
    localparam int C2_MFD_LO = 4;
    localparam int C2_CLOCK_LOSS_RESET_ENABLE = 3;
    localparam int C2_RFD_HI = 2;
    localparam int C2_RFD_LO = 0;
    // status field positions
    localparam int ST_MODE_HI = 1;
    localparam int ST_MODE_LO = 0;
    localparam int ST_STABLE = 2;
    localparam int ST_REFKIND = 3;
    localparam int ST_LOCK_LOSS = 4;
    localparam int ST_CLK_LOSS = 5;
    localparam int ST_BUSY = 6;
    // modes
    localparam logic [1:0] MODE_SCM = 2'h0;
    localparam logic [1:0] MODE_FEI = 2'h1;
    localparam logic [1:0] MODE_FBE = 2'h2;
    localparam logic [1:0] MODE_FEE = 2'h3;
    // loop factors
    localparam logic [6:0] P_LOW_RANGE = 7'h40;
    localparam logic [6:0] P_HIGH_RANGE = 7'h01;
    localparam logic [6:0] P_INTERNAL = 7'h40;
    localparam logic [4:0] N_BASE = 5'h04;
    localparam logic [7:0] R_BASE = 8'h01;
    // cycles for a mode, factor or divider write to complete
    localparam logic [2:0] SYNC_CYCLES = 3'h4;
    localparam logic [7:0] RESET_CTRL_TWO = 8'h00;
    typedef enum logic [1:0] {
        CGC_IDLE = 2'b00,
        CGC_SYNC = 2'b01,
        CGC_WAIT_REF = 2'b11
    } cgc_mode_st_t;
endpackage : cgc_pkg

// ### hw/cgc_top.sv
// clock generator control registers, mode sequencing and loss handling
// assumes apb master on mclk; oscillator status inputs synchronous to mclk
// Behaviour
// - gain, range and reference select take only the first write after reset
// - gain select 0 gives low power, 1 gives high gain oscillator
// - range 0 gives low range with P 64; range 1 high range with P 1
// - range only matters in the two external modes
// - reference select 0 external clock, 1 crystal or resonator
// - mode field 00 self, 01 engaged internal, 10 bypassed ext, 11 engaged ext
// - bypassed external is entered only once the reference is stable
// - entering off mode leaves the mode field untouched
// - mode writes are ignored while a previous mode write is pending
// - first mode write internal locks out external modes until reset
// - oscillator in off mode follows enable, mode and crystal selection; with the off-mode oscillator bit set, mode and crystal selection only
// - off-mode oscillator bit ignored when gain and range are both 1
// - loss detect disable 1 turns off clock loss detection
// - lock loss flag raises interrupt or reset by its reset enable
// - multiplication codes 0 to 7 give N of 4 to 18 in steps of 2
// - multiplication writes ignored while a previous one is pending
// - clock loss raises interrupt or reset by its reset enable
// - divider codes 0 to 7 give R of 1 to 128 in powers of two
// - divider writes ignored while a previous one is pending
// - reference stable flag is 1 only when the reference is good
// - lock loss flag sets on unexpected lock loss, held until cleared
// - reference kind status shows 0 external clock, 1 crystal
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module cgc_top
    import cgc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [cgc_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_ref_ok,
    input wire logic lock_lost,
    input wire logic clock_lost,
    input wire logic off_mode,
    input wire logic enable_in,
    output logic [1:0] active_mode,
    output logic osc_enable,
    output logic osc_high_gain,
    output logic osc_high_range,
    output logic osc_crystal,
    output logic loss_detect_en,
    output logic [6:0] prescale_p,
    output logic [4:0] mult_n,
    output logic [7:0] div_r,
    output logic [11:0] target_mult,
    output logic irq_req,
    output logic reset_req
);
    import cgc_pkg::*;

    typedef struct packed {
        logic high_gain_select;
        logic rng;
        logic ext_reference_select;
        logic once_done;
        logic first_mode_done;
        logic pin_reserved;
        logic sten;
        logic loss_detect_disable;
        logic [1:0] req_mode;
        logic [1:0] act_mode;
        cgc_mode_st_t mode_st;
        logic [2:0] mode_cnt;
        logic lock_loss_reset_enable;
        logic clock_loss_reset_enable;
        logic [2:0] req_mfd;
        logic [2:0] act_mfd;
        logic [2:0] mfd_cnt;
        logic [2:0] req_rfd;
        logic [2:0] act_rfd;
        logic [2:0] rfd_cnt;
        logic ref_stable;
        logic lock_flag;
        logic loss_flag;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic osc_enable;
        logic osc_high_range;
        logic [6:0] prescale_p;
        logic [4:0] mult_n;
        logic [7:0] div_r;
        logic [11:0] target_mult;
        logic irq_req;
        logic reset_req;
        logic loss_en;
    } cgc_state_t;

    cgc_state_t s;
    cgc_state_t next_s;
    logic acc;
    logic wr_one;
    logic wr_two;
    logic wr_st;
    logic [7:0] rd_one;
    logic [7:0] rd_two;
    logic [7:0] rd_st;
    logic eff_sten;

    always_comb begin
        next_s = s;
        acc = psel && penable && s.pready;
        wr_one = acc && pwrite && (paddr == OFF_CTRL_ONE);
        wr_two = acc && pwrite && (paddr == OFF_CTRL_TWO);
        wr_st = acc && pwrite && (paddr == OFF_STATUS);
        rd_one = {s.high_gain_select, s.rng, s.ext_reference_select, s.req_mode, s.sten, s.loss_detect_disable, 1'b0};
        rd_two = {s.lock_loss_reset_enable, s.req_mfd, s.clock_loss_reset_enable, s.req_rfd};
        rd_st = {1'b0, (s.mode_st != CGC_IDLE) || (s.mfd_cnt != 3'h0) || (s.rfd_cnt != 3'h0),
                 s.loss_flag, s.lock_flag, s.ext_reference_select, s.ref_stable, s.act_mode};
        // apb: one wait cycle, answer registered
        next_s.pready = 1'b0;
        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.pslverr = 1'b0;
            case (paddr)
                OFF_CTRL_ONE: next_s.prdata = {24'h000000, rd_one};
                OFF_CTRL_TWO: next_s.prdata = {24'h000000, rd_two};
                OFF_STATUS: next_s.prdata = {24'h000000, rd_st};
                default: begin
                    next_s.prdata = 32'h00000000;
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        // control one
        if (wr_one) begin
            next_s.sten = pwdata[C1_STEN];
            next_s.loss_detect_disable = pwdata[C1_LOSS_DETECT_DISABLE];
            if (!s.once_done) begin
                next_s.high_gain_select = pwdata[C1_HGO];
                next_s.rng = pwdata[C1_RANGE];
                next_s.ext_reference_select = pwdata[C1_EXT_REFERENCE_SELECT];
                next_s.once_done = 1'b1;
            end
            // off mode does not touch the mode field
            if (s.mode_st == CGC_IDLE) begin
                if (!s.first_mode_done) begin
                    next_s.first_mode_done = 1'b1;
                    next_s.pin_reserved = pwdata[C1_MODE_HI];
                end
                if (!(s.first_mode_done && !s.pin_reserved && pwdata[C1_MODE_HI])) begin
                    next_s.req_mode = pwdata[C1_MODE_HI:C1_MODE_LO];
                    next_s.mode_st = CGC_SYNC;
                    next_s.mode_cnt = SYNC_CYCLES - 3'h1;
                end
            end
        end
        // mode sequencing
        case (s.mode_st)
            CGC_IDLE: begin
            end
            CGC_SYNC: begin
                if (s.mode_cnt != 3'h0) begin
                    next_s.mode_cnt = s.mode_cnt - 3'h1;
                end else if (s.req_mode == MODE_FBE && !s.ref_stable) begin
                    next_s.mode_st = CGC_WAIT_REF;
                end else begin
                    next_s.act_mode = s.req_mode;
                    next_s.mode_st = CGC_IDLE;
                end
            end
            CGC_WAIT_REF: begin
                if (s.ref_stable) begin
                    next_s.act_mode = s.req_mode;
                    next_s.mode_st = CGC_IDLE;
                end
            end
            default: next_s.mode_st = CGC_IDLE;
        endcase
        // control two
        if (wr_two) begin
            next_s.lock_loss_reset_enable = pwdata[C2_LOCK_LOSS_RESET_ENABLE];
            next_s.clock_loss_reset_enable = pwdata[C2_CLOCK_LOSS_RESET_ENABLE];
            if (s.mfd_cnt == 3'h0) begin
                next_s.req_mfd = pwdata[C2_MFD_HI:C2_MFD_LO];
                next_s.mfd_cnt = SYNC_CYCLES;
            end
            if (s.rfd_cnt == 3'h0) begin
                next_s.req_rfd = pwdata[C2_RFD_HI:C2_RFD_LO];
                next_s.rfd_cnt = SYNC_CYCLES;
            end
        end
        if (s.mfd_cnt != 3'h0) begin
            next_s.mfd_cnt = s.mfd_cnt - 3'h1;
            if (s.mfd_cnt == 3'h1) begin
                next_s.act_mfd = s.req_mfd;
            end
        end
        if (s.rfd_cnt != 3'h0) begin
            next_s.rfd_cnt = s.rfd_cnt - 3'h1;
            if (s.rfd_cnt == 3'h1) begin
                next_s.act_rfd = s.req_rfd;
            end
        end
        // status flags, set beats clear
        next_s.ref_stable = ext_ref_ok;
        if (wr_st && pwdata[ST_LOCK_LOSS]) begin
            next_s.lock_flag = 1'b0;
        end
        if (lock_lost) begin
            next_s.lock_flag = 1'b1;
        end
        if (wr_st && pwdata[ST_CLK_LOSS]) begin
            next_s.loss_flag = 1'b0;
        end
        if (clock_lost && !s.loss_detect_disable) begin
            next_s.loss_flag = 1'b1;
        end
        // oscillator and loop outputs
        eff_sten = next_s.sten && !(next_s.high_gain_select && next_s.rng);
        if (!off_mode) begin
            next_s.osc_enable = next_s.pin_reserved && next_s.act_mode[1];
        end else if (eff_sten) begin
            next_s.osc_enable = next_s.req_mode[1] && next_s.ext_reference_select;
        end else begin
            next_s.osc_enable = enable_in && (next_s.req_mode == MODE_FBE) && next_s.ext_reference_select;
        end
        if (next_s.act_mode[1]) begin
            next_s.osc_high_range = next_s.rng;
            next_s.prescale_p = next_s.rng ? P_HIGH_RANGE : P_LOW_RANGE;
        end else begin
            next_s.osc_high_range = 1'b0;
            next_s.prescale_p = P_INTERNAL;
        end
        next_s.mult_n = N_BASE + {1'b0, next_s.act_mfd, 1'b0};
        next_s.div_r = R_BASE << next_s.act_rfd;
        next_s.target_mult = 12'(next_s.prescale_p * next_s.mult_n);
        next_s.irq_req = (next_s.lock_flag && !next_s.lock_loss_reset_enable)
                         || (next_s.loss_flag && !next_s.clock_loss_reset_enable);
        next_s.reset_req = (next_s.lock_flag && next_s.lock_loss_reset_enable)
                           || (next_s.loss_flag && next_s.clock_loss_reset_enable);
        next_s.loss_en = !next_s.loss_detect_disable;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.mode_st <= CGC_IDLE;
            s.lock_loss_reset_enable <= RESET_CTRL_TWO[C2_LOCK_LOSS_RESET_ENABLE];
            s.prescale_p <= P_INTERNAL;
            s.mult_n <= N_BASE;
            s.div_r <= R_BASE;
            s.target_mult <= 12'h100;
            s.loss_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign active_mode = s.act_mode;
    assign osc_enable = s.osc_enable;
    assign osc_high_gain = s.high_gain_select;
    assign osc_high_range = s.osc_high_range;
    assign osc_crystal = s.ext_reference_select;
    assign loss_detect_en = s.loss_en;
    assign prescale_p = s.prescale_p;
    assign mult_n = s.mult_n;
    assign div_r = s.div_r;
    assign target_mult = s.target_mult;
    assign irq_req = s.irq_req;
    assign reset_req = s.reset_req;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    write_once_a: assert property (s.once_done && wr_one |=> $stable(osc_high_gain)
        && $stable(osc_crystal) && $stable(s.rng)) else $error("write-once bit changed");
    prescale_sel_a: assert property (##1 prescale_p == (active_mode[1] ?
        (s.rng ? P_HIGH_RANGE : P_LOW_RANGE) : P_INTERNAL)) else $error("prescale wrong");
    fbe_wait_a: assert property ($changed(s.act_mode) && s.act_mode == MODE_FBE
        |-> $past(s.ref_stable)) else $error("bypass entered without stable ref");
    mode_busy_a: assert property (s.mode_st != CGC_IDLE && wr_one
        |=> $stable(s.req_mode)) else $error("mode write taken while busy");
    pin_refuse_a: assert property (s.first_mode_done && !s.pin_reserved
        |-> !s.req_mode[1]) else $error("external mode without reserved pin");
    mult_map_a: assert property (##1 mult_n == N_BASE + {1'b0, s.act_mfd, 1'b0})
        else $error("multiplication factor wrong");
    div_map_a: assert property (##1 div_r == (R_BASE << s.act_rfd))
        else $error("divider wrong");
    mfd_delay_a: assert property (wr_two && s.mfd_cnt == 3'h0
        |-> ##5 s.act_mfd == $past(pwdata[C2_MFD_HI:C2_MFD_LO], 5)) else $error("mfd late");
    lock_set_a: assert property (lock_lost |=> s.lock_flag)
        else $error("lock loss flag not set");
    lock_action_a: assert property (s.lock_flag && !s.lock_loss_reset_enable |-> irq_req)
        else $error("lock loss interrupt missing");
    clk_loss_a: assert property (clock_lost && !s.loss_detect_disable && s.clock_loss_reset_enable
        |=> ##[0:1] reset_req) else $error("clock loss reset missing");

    mfd_busy_a: assert property (wr_two && s.mfd_cnt != 3'h0
        |=> $stable(s.req_mfd)) else $error("mfd write taken while busy");
    rfd_busy_a: assert property (wr_two && s.rfd_cnt != 3'h0
        |=> $stable(s.req_rfd)) else $error("rfd write taken while busy");
    rfd_delay_a: assert property (wr_two && s.rfd_cnt == 3'h0
        |-> ##5 s.act_rfd == $past(pwdata[C2_RFD_HI:C2_RFD_LO], 5)) else $error("rfd late");
    loss_off_a: assert property (clock_lost && s.loss_detect_disable && !s.loss_flag
        |=> !s.loss_flag) else $error("clock loss seen while detection off");
    range_map_a: assert property (!active_mode[1]
        |-> !osc_high_range && prescale_p == P_INTERNAL) else $error("range leaked");
    stable_flag_a: assert property (##1 s.ref_stable == $past(ext_ref_ok))
        else $error("stable flag wrong");
    ref_kind_a: assert property (acc && !pwrite && paddr == OFF_STATUS
        |-> prdata[ST_REFKIND] == osc_crystal) else $error("reference kind status wrong");
    lock_reset_a: assert property (s.lock_flag && s.lock_loss_reset_enable |-> reset_req)
        else $error("lock loss reset missing");
    clk_irq_a: assert property (s.loss_flag && !s.clock_loss_reset_enable |-> irq_req)
        else $error("clock loss interrupt missing");
    irq_quiet_a: assert property (!s.lock_flag && !s.loss_flag
        |-> !irq_req && !reset_req) else $error("request without flag");
    wait_mode_a: assert property (s.mode_st == CGC_WAIT_REF |-> s.req_mode == MODE_FBE)
        else $error("waiting on reference outside bypass");
    off_sten_a: assert property (off_mode && !wr_one && s.sten && !(s.high_gain_select && s.rng)
        && s.req_mode[1] && s.ext_reference_select
        |=> osc_enable) else $error("oscillator off in off mode");
    off_enable_a: assert property (off_mode && !wr_one && !s.sten && enable_in
        && s.req_mode == MODE_FBE && s.ext_reference_select
        |=> osc_enable) else $error("enable ignored");
    off_idle_a: assert property (off_mode && !wr_one && !s.sten && !enable_in
        |=> !osc_enable) else $error("oscillator left on in off mode");
    off_ignore_a: assert property (off_mode && !enable_in && s.high_gain_select && s.rng
        |=> !osc_enable) else $error("off-mode bit not ignored");

    fbe_entry_c: cover property (s.mode_st == CGC_WAIT_REF ##[1:20] s.act_mode == MODE_FBE);
    refused_c: cover property (wr_one && s.first_mode_done && !s.pin_reserved && pwdata[C1_MODE_HI]);
    off_osc_c: cover property (off_mode && osc_enable);
    lock_clear_c: cover property (s.lock_flag ##1 !s.lock_flag);
    fee_c: cover property (s.act_mode == MODE_FEE && s.mult_n == 5'h12);
endmodule : cgc_top

// ### sim/cgc_ref_src.sv
// model of the square-wave reference source on the reference input pin
// assumes the bench powers it by running; stable START_CYC+1 mclk cycles after running rises
`timescale 1ns/1ps
module cgc_ref_src #(
    parameter int START_CYC = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic running,
    output logic ext_ref_ok
);
    int cnt;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst || !running) begin
            cnt <= 0;
            ext_ref_ok <= 1'h0;
        end else begin
            if (cnt < START_CYC) begin
                cnt <= cnt + 1;
            end
            ext_ref_ok <= (cnt >= START_CYC);
        end
    end
endmodule : cgc_ref_src

// ### sim/test_clock_generator_control.sv
// self-checking bench of the clock generator control block over apb
// assumes cgc_pkg and cgc_top from hw/, reference model from sim/
`timescale 1ns/1ps
module test_clock_generator_control;
    import cgc_pkg::*;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0;
    logic lock_lost = 1'h0;
    logic clock_lost = 1'h0;
    logic off_mode = 1'h0;
    logic enable_in = 1'h0;
    logic running = 1'h0;
    logic ext_ref_ok;
    logic [31:0] prdata;
    logic [1:0] active_mode;
    logic pready, pslverr, osc_enable, osc_high_gain, osc_high_range, osc_crystal;
    logic loss_detect_en, irq_req, reset_req;
    logic [6:0] prescale_p;
    logic [4:0] mult_n;
    logic [7:0] div_r;
    logic [11:0] target_mult;
    logic [31:0] q;
    logic last_err;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    cgc_top u_dut (.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .ext_ref_ok, .lock_lost, .clock_lost, .off_mode, .enable_in, .active_mode,
        .osc_enable, .osc_high_gain, .osc_high_range, .osc_crystal, .loss_detect_en,
        .prescale_p, .mult_n, .div_r, .target_mult, .irq_req, .reset_req);
    cgc_ref_src #(.START_CYC(16)) u_src (.mclk, .rst, .running, .ext_ref_ok);
    always #20 mclk = ~mclk;
    task end_of_test;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one transfer; psel stays up so a following call is back to back
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        q = prdata;
        last_err = pslverr;
        penable <= 1'h0;
    endtask : apb
    task idle;
        psel <= 1'h0;
        @(posedge mclk);
    endtask : idle
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
        idle();
    endtask : wr
    task rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
        idle();
    endtask : rd
    task settle;
        for (int n = 0; n < 60; n++) begin
            rd(OFF_STATUS);
            if (q[ST_BUSY] === 1'h0) break;
        end
        chk(q[ST_BUSY], 1'h0);
        repeat (2) @(posedge mclk);
    endtask : settle
    task do_reset;
        rst <= 1'h1;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
    endtask : do_reset
    initial begin
        do_reset();
        chk({prescale_p, mult_n, div_r, loss_detect_en}, 21'h100803);
        chk(target_mult, 12'h100);
        rd(OFF_CTRL_TWO);
        chk(q, 32'h0);
        rd(8'h0C);
        chk(last_err, 1'h1);
        for (int c = 0; c < 8; c++) begin
            wr(OFF_CTRL_TWO, {25'h0, c[2:0], 1'h0, c[2:0]});
            settle();
            chk(mult_n, 4 + 2 * c);
            chk(div_r, 1 << c);
            chk(target_mult, 64 * (4 + 2 * c));
        end
        apb(1'h1, OFF_CTRL_TWO, 32'h22);
        apb(1'h1, OFF_CTRL_TWO, 32'h55);
        idle();
        settle();
        chk({mult_n, div_r}, {5'h08, 8'h04});
        wr(OFF_CTRL_ONE, 32'hB2);
        repeat (10) @(posedge mclk);
        chk({osc_high_gain, osc_crystal, loss_detect_en}, 3'h6);
        chk(active_mode, MODE_SCM);
        running <= 1'h1;
        settle();
        chk(active_mode, MODE_FBE);
        rd(OFF_STATUS);
        chk(q[3:0], 4'hE);
        chk(prescale_p, 7'h40);
        clock_lost <= 1'h1;
        @(posedge mclk);
        clock_lost <= 1'h0;
        repeat (3) @(posedge mclk);
        chk({irq_req, reset_req}, 2'h0);
        off_mode <= 1'h1;
        enable_in <= 1'h1;
        repeat (3) @(posedge mclk);
        chk(osc_enable, 1'h1);
        enable_in <= 1'h0;
        repeat (3) @(posedge mclk);
        chk(osc_enable, 1'h0);
        rd(OFF_CTRL_ONE);
        chk({q[4:3], active_mode}, 4'hA);
        off_mode <= 1'h0;
        wr(OFF_CTRL_ONE, 32'h58);
        settle();
        chk({osc_high_gain, osc_crystal, loss_detect_en}, 3'h7);
        chk(active_mode, MODE_FEE);
        chk(target_mult, 12'h200);
        clock_lost <= 1'h1;
        @(posedge mclk);
        clock_lost <= 1'h0;
        repeat (3) @(posedge mclk);
        chk({irq_req, reset_req}, 2'h2);
        wr(OFF_STATUS, 32'h30);
        wr(OFF_CTRL_TWO, 32'hAD);
        lock_lost <= 1'h1;
        @(posedge mclk);
        lock_lost <= 1'h0;
        repeat (10) @(posedge mclk);
        chk({irq_req, reset_req}, 2'h1);
        rd(OFF_STATUS);
        chk(q[ST_LOCK_LOSS], 1'h1);
        do_reset();
        wr(OFF_CTRL_ONE, 32'h48);
        settle();
        chk({osc_high_range, prescale_p}, 8'h40);
        wr(OFF_CTRL_ONE, 32'h18);
        settle();
        chk(active_mode, MODE_FEI);
        apb(1'h1, OFF_CTRL_ONE, 32'h00);
        apb(1'h1, OFF_CTRL_ONE, 32'h08);
        idle();
        settle();
        chk(active_mode, MODE_SCM);
        do_reset();
        wr(OFF_CTRL_ONE, 32'h7C);
        wr(OFF_CTRL_TWO, 32'h08);
        settle();
        chk({osc_high_range, prescale_p}, 8'h81);
        chk(target_mult, 12'h004);
        clock_lost <= 1'h1;
        lock_lost <= 1'h1;
        @(posedge mclk);
        clock_lost <= 1'h0;
        lock_lost <= 1'h0;
        repeat (3) @(posedge mclk);
        chk({irq_req, reset_req}, 2'h3);
        off_mode <= 1'h1;
        repeat (3) @(posedge mclk);
        chk(osc_enable, 1'h1);
        off_mode <= 1'h0;
        do_reset();
        wr(OFF_CTRL_ONE, 32'hFC);
        settle();
        off_mode <= 1'h1;
        repeat (3) @(posedge mclk);
        chk(osc_enable, 1'h0);
        off_mode <= 1'h0;
        end_of_test();
    end
endmodule : test_clock_generator_control
